// *** rtl/gcc_defs.vh ***
// Constants for the bus controller command timing block
`ifndef GCC_DEFS_VH
`define GCC_DEFS_VH
// Instruction cycle time in ns and clocks per instruction cycle at 50 MHz
`define GCC_TCY_NS        2500
`define GCC_CLK_NS        20
`define GCC_TCY_CLKS      (`GCC_TCY_NS / `GCC_CLK_NS)
// Last divider count of an instruction cycle, one less than the clocks per cycle
`define GCC_TCY_LAST      8'd124
// Command codes
`define GCC_CMD_STOPCNT   8'hf0
`define GCC_CMD_RESET     8'hf2
`define GCC_CMD_STARTCNT  8'hfe
// Acknowledge pattern: bits 3,1,0 set
`define GCC_ACK_MASK      8'h0b
// Cycle points, counted from the command interrupt
`define GCC_IBF_CYC       8'd24
`define GCC_TCI_CLR_CYC   8'd7
`define GCC_STOP_CYC      8'd39
`define GCC_STOP_END      8'd53
`define GCC_RST_END       8'd94
`define GCC_RST_SC_END    8'd214
`define GCC_ACK_END       8'd116
`define GCC_ACK_FALL      8'd73
`define GCC_ACK_RISE      8'd98
`define GCC_GEN_END       8'd60
`define GCC_START_END     8'd59
`endif

// *** rtl/gcc_tick.v ***
// Instruction cycle tick generator
`timescale 1ns/1ps
`include "gcc_defs.vh"
module gcc_tick
(
    input  wire       clk,
    input  wire       rstn,
    input  wire       restart,
    output reg        tick_reg
);
    reg [7:0] div_reg;

    // Restart aligns cycle 0 with the command interrupt
    always @(posedge clk)
    begin
        if (!rstn || restart)
        begin
            div_reg  <= 8'h00;
            tick_reg <= 1'b0;
        end
        else if (div_reg == `GCC_TCY_LAST)
        begin
            div_reg  <= 8'h00;
            tick_reg <= 1'b1;
        end
        else
        begin
            div_reg  <= div_reg + 8'h01;
            tick_reg <= 1'b0;
        end
    end
endmodule

// *** rtl/gcc_core.v ***
// Command execution sequencer of the bus controller
// Operation
// - Count all timings in instruction cycles
// - Clear task done seven cycles in
// - Stop counter halts at 39, ends 53
// - Reset takes 94, or 214 controlling
// - Acknowledge 116 cycles with interrupt pending, fall 73 rise 98; else 60
// - New command clears pending task done
// - Acknowledge decoded from unused byte pattern
// - After reset controller enters active state only if strapped
// - Output buffer interrupt follows the buffer flag
`timescale 1ns/1ps
`include "gcc_defs.vh"
module gcc_core
(
    input  wire       clk,
    input  wire       rstn,
    input  wire       cmd_wr,
    input  wire [7:0] cmd_data,
    input  wire       sys_ctrl,
    input  wire       irq_pending,
    input  wire       outbuf_flag,
    output reg        task_done_irq,
    output reg        inbuf_free_irq,
    output reg        outbuf_full_irq,
    output reg        counter_run,
    output reg        ack_line,
    output reg        ctrl_active_state,
    output reg        ctrl_idle_state,
    output reg        busy
);
    // Timing model: every point is a whole instruction cycle of 125 clocks,
    // counted from the write, which also restarts the tick divider. The
    // first tick lands 125 clocks after the write, so an output that moves
    // at cycle n shows 125*n + 1 clocks after the write edge. Realigning
    // the tick on each write keeps a partial cycle of the previous command
    // from shifting the next one.
    // A write while busy aborts the running command and starts the new one.
    // Limitation: an abort while the acknowledge line is low leaves it low
    // until a later acknowledge with an interrupt pending reaches cycle 98,
    // so the master must not write then.

    // Sequencer states; boot runs once after the pin reset
    localparam ST_IDLE = 2'd0;
    localparam ST_EXEC = 2'd1;
    localparam ST_BOOT = 2'd2;

    // Command kinds that need timing points of their own
    localparam K_GEN  = 2'd0;
    localparam K_STOP = 2'd1;
    localparam K_RST  = 2'd2;
    localparam K_ACK  = 2'd3;

    // Sequencer state and the running command
    reg [1:0] state_reg;
    reg [1:0] kind_reg;
    reg [7:0] cyc_reg;
    reg [7:0] end_reg;
    reg       sc_reg;
    // One pulse per instruction cycle, realigned on every write
    wire      tick;

    // Recognise the acknowledge pattern; utilities never use it
    function is_ack;
        input [7:0] b;
        begin
            is_ack = ((b & `GCC_ACK_MASK) == `GCC_ACK_MASK);
        end
    endfunction

    // True when the coming tick reaches the given instruction cycle
    function at_cycle;
        input [7:0] cnt;
        input [7:0] point;
        begin
            at_cycle = (cnt + 8'h01 == point);
        end
    endfunction

    gcc_tick u_tick
    (
        .clk      (clk),
        .rstn     (rstn),
        .restart  (cmd_wr),
        .tick_reg (tick)
    );

    // Buffer full interrupt is a plain registered copy of the flag, kept
    // apart from the sequencer so no command can hold it back
    always @(posedge clk)
    begin
        if (!rstn)
            outbuf_full_irq <= 1'b0;
        else
            outbuf_full_irq <= outbuf_flag;
    end

    // Sequencer; a write while busy is taken as a new command, as the
    // master is told it may preload once input free returns
    always @(posedge clk)
    begin
        if (!rstn)
        begin
            // Pin reset: every output but input free at its idle level, boot step next
            state_reg         <= ST_BOOT;
            kind_reg          <= K_RST;
            cyc_reg           <= 8'h00;
            end_reg           <= `GCC_RST_END;
            sc_reg            <= 1'b0;
            task_done_irq     <= 1'b0;
            inbuf_free_irq    <= 1'b0;
            counter_run       <= 1'b0;
            ack_line          <= 1'b1;
            ctrl_active_state <= 1'b0;
            ctrl_idle_state   <= 1'b1;
            busy              <= 1'b0;
        end
        else
        begin
            if (cmd_wr)
            begin
                state_reg      <= ST_EXEC;
                cyc_reg        <= 8'h00;
                inbuf_free_irq <= 1'b0;
                busy           <= 1'b1;
                // A new command clears task done, but a completion of the
                // aborted command on this very edge still wins
                task_done_irq  <= tick && state_reg == ST_EXEC && at_cycle(cyc_reg, end_reg);
                // Decode the byte into its kind and execution length
                if (is_ack(cmd_data) && cmd_data[7:4] != 4'hf && cmd_data[7:4] != 4'he)
                begin
                    // Acknowledge runs long only with an interrupt pending
                    kind_reg <= K_ACK;
                    end_reg  <= irq_pending ? `GCC_ACK_END : `GCC_GEN_END;
                end
                else if (cmd_data == `GCC_CMD_STOPCNT)
                begin
                    // Halt point lies well inside the command
                    kind_reg <= K_STOP;
                    end_reg  <= `GCC_STOP_END;
                end
                else if (cmd_data == `GCC_CMD_STARTCNT)
                begin
                    // Counter runs from the write; only its halt is timed
                    kind_reg    <= K_GEN;
                    end_reg     <= `GCC_START_END;
                    counter_run <= 1'b1;
                end
                else if (cmd_data == `GCC_CMD_RESET)
                begin
                    // System controller also runs the abort, hence the longer count
                    kind_reg <= K_RST;
                    sc_reg   <= sys_ctrl;
                    end_reg  <= sys_ctrl ? `GCC_RST_SC_END : `GCC_RST_END;
                end
                else
                begin
                    kind_reg <= K_GEN;
                    end_reg  <= `GCC_GEN_END;
                end
            end
            else
            begin
                case (state_reg)
                    // Boot: settle the controller state once the pin reset lets go
                    ST_BOOT:
                    begin
                        // Pin reset: controller goes active only if strapped
                        ctrl_active_state <= sys_ctrl;
                        ctrl_idle_state   <= ~sys_ctrl;
                        inbuf_free_irq    <= 1'b1;
                        state_reg         <= ST_IDLE;
                    end
                    ST_EXEC:
                    begin
                        // Each point fires on the tick that reaches its cycle
                        if (tick)
                        begin
                            cyc_reg <= cyc_reg + 8'h01;
                            if (at_cycle(cyc_reg, `GCC_TCI_CLR_CYC))
                                task_done_irq <= 1'b0;
                            if (at_cycle(cyc_reg, `GCC_IBF_CYC))
                                inbuf_free_irq <= 1'b1;
                            if (kind_reg == K_STOP && at_cycle(cyc_reg, `GCC_STOP_CYC))
                                counter_run <= 1'b0;
                            if (kind_reg == K_ACK && end_reg == `GCC_ACK_END
                                && at_cycle(cyc_reg, `GCC_ACK_FALL))
                                ack_line <= 1'b0;
                            if (kind_reg == K_ACK && at_cycle(cyc_reg, `GCC_ACK_RISE))
                                ack_line <= 1'b1;
                            // Completion raises task done; a reset command
                            // then settles the controller state
                            if (at_cycle(cyc_reg, end_reg))
                            begin
                                state_reg     <= ST_IDLE;
                                busy          <= 1'b0;
                                task_done_irq <= 1'b1;
                                if (kind_reg == K_RST)
                                begin
                                    counter_run       <= 1'b0;
                                    ctrl_active_state <= sc_reg;
                                    ctrl_idle_state   <= ~sc_reg;
                                end
                            end
                        end
                    end
                    ST_IDLE:
                    begin
                        // Nothing to run, so the input buffer stays free
                        inbuf_free_irq <= 1'b1;
                    end
                    default:
                    begin
                        // Unused code: fall back to idle
                        state_reg <= ST_IDLE;
                    end
                endcase
            end
        end
    end
    // The master, not this block, waits for the companion interrupt before
    // standby and secondary commands; nothing here can check that order
endmodule

// *** bench/gcc_core_assertions.sv ***
// Port timing checker of the command sequencer
`timescale 1ns/1ps
module gcc_core_assertions
(
    input wire clk,
    input wire rstn,
    input wire cmd_wr,
    input wire irq_pending,
    input wire outbuf_flag,
    input wire task_done_irq,
    input wire inbuf_free_irq,
    input wire outbuf_full_irq,
    input wire counter_run,
    input wire ack_line,
    input wire ctrl_active_state,
    input wire ctrl_idle_state,
    input wire busy
);
    reg [14:0] wr_cnt;
    reg [11:0] lo_cnt;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Counters, since long spans cannot be written as repetitions
    always @(posedge clk)
    begin
        wr_cnt <= (cmd_wr || !rstn) ? 15'h0 : wr_cnt + 15'h1;
        lo_cnt <= ack_line ? 12'h0 : lo_cnt + 12'h1;
    end
    a_busy_start: assert property (cmd_wr |=> busy) else $error("busy late");
    a_done_clear: assert property (cmd_wr |-> ##[1:880] !task_done_irq) else $error("done kept");
    a_inbuf_drop: assert property (cmd_wr |=> !inbuf_free_irq) else $error("inbuf kept");
    a_inbuf_back: assert property ($rose(inbuf_free_irq) && busy |->
        wr_cnt > 15'hbb2 && wr_cnt < 15'hbbe) else $error("inbuf time");
    a_done_len: assert property ($rose(task_done_irq) |->
        (wr_cnt / 15'h7d) inside {15'h35, 15'h3b, 15'h3c, 15'h5e, 15'h74, 15'hd6}) else $error("done time");
    a_outbuf_follow: assert property (outbuf_full_irq == $past(outbuf_flag)) else $error("outbuf");
    a_ack_cause: assert property ($fell(ack_line) |-> busy && irq_pending) else $error("ack cause");
    a_ack_width: assert property ($rose(ack_line) |->
        lo_cnt > 12'hc2a && lo_cnt < 12'hc40) else $error("ack width");
    a_counter_hold: assert property (!counter_run && !cmd_wr |=> !counter_run) else $error("counter");
    a_counter_stop: assert property ($fell(counter_run) && busy |-> wr_cnt == 15'h130c) else $error("halt time");
    a_state_excl: assert property (ctrl_active_state != ctrl_idle_state) else $error("state");
endmodule

// *** bench/gcc_master.sv ***
// Master processor model writing command bytes
`timescale 1ns/1ps
module gcc_master
(
    input  wire       clk,
    input  wire       inbuf_free_irq,
    output reg        cmd_wr,
    output reg  [7:0] cmd_data
);
    initial cmd_wr = 1'b0;
    initial cmd_data = 8'h5a;
    // A byte is only offered once the input buffer is free
    task send(input [7:0] b);
    begin
        @(negedge clk);
        while (inbuf_free_irq !== 1'b1)
            @(negedge clk);
        cmd_data = b;
        cmd_wr = 1'b1;
        @(negedge clk);
        cmd_wr = 1'b0;
        cmd_data = ~b;
    end
    endtask
endmodule

// *** bench/gcc_core_tb.sv ***
// Self-checking bench of the command sequencer
`timescale 1ns/1ps
module gcc_core_tb;
    reg        clk = 1'b0;
    reg        rstn = 1'b0;
    reg        sys_ctrl = 1'b0;
    reg        irq_pending = 1'b0;
    reg        outbuf_flag = 1'b0;
    reg [31:0] lfsr = 32'h286f;
    reg [15:0] clks = 16'h0;
    reg        done_d = 1'b0;
    integer    n_errors = 0;
    integer    comparisons = 0;
    integer    expq[$];
    wire       cmd_wr;
    wire [7:0] cmd_data;
    wire [7:0] o;
    gcc_master m (.clk(clk), .inbuf_free_irq(o[1]), .cmd_wr(cmd_wr), .cmd_data(cmd_data));
    gcc_core dut (.clk(clk), .rstn(rstn), .cmd_wr(cmd_wr), .cmd_data(cmd_data), .sys_ctrl(sys_ctrl),
        .irq_pending(irq_pending), .outbuf_flag(outbuf_flag), .task_done_irq(o[0]), .inbuf_free_irq(o[1]),
        .outbuf_full_irq(o[2]), .counter_run(o[3]), .ack_line(o[4]), .ctrl_active_state(o[5]),
        .ctrl_idle_state(o[6]), .busy(o[7]));
    always #10 clk = ~clk;
    // Random buffer flag, held low in reset
    always @(negedge clk)
    begin
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        outbuf_flag = rstn & lfsr[3];
    end
    task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
    begin
        comparisons = comparisons + 1;
        if (g !== e)
        begin
            n_errors = n_errors + 1;
            $display("Error %0s expected %0d seen %0d", nm, e, g);
        end
    end
    endtask
    // Each completion is timed in instruction cycles against the oldest note
    always @(posedge clk)
    begin
        clks <= cmd_wr ? 16'h0 : clks + 16'h1;
        done_d <= o[0];
        if (o[0] === 1'b1 && done_d === 1'b0 && expq.size() > 0)
            chk("cycles", expq.pop_front(), clks / 16'h7d);
    end
    task run(input [7:0] b, input [31:0] e);
        integer i;
    begin
        if (e != 0)
            expq.push_back(e);
        m.send(b);
        for (i = 0; i < 30000 && e != 0 && o[7] !== 1'b0; i = i + 1)
            @(negedge clk);
        repeat (3) @(negedge clk);
        if (e != 0)
            chk("busy", 32'h0, o[7]);
        $display("test %h done", b);
    end
    endtask
    task end_sim;
    begin
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask
    initial
    begin
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        repeat (2) @(negedge clk);
        chk("idle0", 32'h1, o[6]);
        run(lfsr[7:0] & 8'h77, 32'h3c);
        run(8'h12, 32'h0);
        chk("done", 32'h0, o[0]);
        run(8'hfe, 32'h3b);
        chk("running", 32'h1, o[3]);
        run(8'hf0, 32'h35);
        chk("counter", 32'h0, o[3]);
        irq_pending = 1'b1;
        run((lfsr[7:0] & 8'h7f) | 8'h0b, 32'h74);
        irq_pending = 1'b0;
        chk("ackidle", 32'h1, o[4]);
        run(8'h0b, 32'h3c);
        run(8'hf2, 32'h5e);
        chk("idle", 32'h1, o[6]);
        sys_ctrl = 1'b1;
        run(8'hf2, 32'hd6);
        chk("active", 32'h1, o[5]);
        // Second pin reset with the controller strap set
        rstn = 1'b0;
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        repeat (2) @(negedge clk);
        chk("pinrst", 32'h1, o[5]);
        $display("test pin reset done");
        chk("left", 32'h0, expq.size());
        end_sim;
    end
    // Watchdog sized above the whole command sequence
    initial
    begin
        #1900000;
        n_errors = n_errors + 1;
        end_sim;
    end
endmodule
bind gcc_core gcc_core_assertions u_chk (.clk(clk), .rstn(rstn), .cmd_wr(cmd_wr), .irq_pending(irq_pending),
    .outbuf_flag(outbuf_flag), .task_done_irq(task_done_irq), .inbuf_free_irq(inbuf_free_irq),
    .outbuf_full_irq(outbuf_full_irq), .counter_run(counter_run), .ack_line(ack_line),
    .ctrl_active_state(ctrl_active_state), .ctrl_idle_state(ctrl_idle_state), .busy(busy));
